// >>> core/video_timing_generator.sv
// Video timing generator: pixel buffer, frame lock and sync/blank timing
`timescale 1ns/10ps
`include "vtg_map.svh"
module video_timing_generator import vtg_pkg::*; #(
	parameter int         CHANNEL_BIT_WIDTH = 8,    // Bits per colour channel
	parameter int         BUF_AW            = 4,    // Buffer depth is 2**BUF_AW
	parameter int         PIX_DIV           = 1,    // Clocks per pixel
	parameter bit         INTERLACE         = 1'b0, // Build-time interlace select
	parameter bit         START_FIELD       = 1'b0  // 0 first field, 1 second
) (
	// Clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Horizontal timing, in pixels
	input  wire logic [15:0]                    line_sync_pixels,
	input  wire logic [15:0]                    line_back_porch,
	input  wire logic [15:0]                    line_front_porch,
	input  wire logic [15:0]                    line_active_pixels,
	input  wire logic [15:0]                    line_total_pixels,
	// Vertical timing, frame or first field, in lines
	input  wire logic [15:0]                    frame_sync_lines,
	input  wire logic [15:0]                    frame_back_porch,
	input  wire logic [15:0]                    frame_front_porch,
	input  wire logic [15:0]                    frame_active_lines,
	input  wire logic [15:0]                    frame_total_lines,
	// Vertical timing, second field, in lines
	input  wire logic [15:0]                    second_field_sync_lines,
	input  wire logic [15:0]                    second_field_back_porch,
	input  wire logic [15:0]                    second_field_front_porch,
	input  wire logic [15:0]                    second_field_active_lines,
	input  wire logic [15:0]                    second_field_total_lines,
	// Pixel input stream
	input  wire logic [3*CHANNEL_BIT_WIDTH-1:0] in_pixel,
	input  wire logic                           in_frame_start,
	input  wire logic                           in_line_start,
	input  wire logic                           in_valid,
	output logic                                in_ready,
	// Video output
	output logic      [CHANNEL_BIT_WIDTH-1:0]   vid_r,
	output logic      [CHANNEL_BIT_WIDTH-1:0]   vid_g,
	output logic      [CHANNEL_BIT_WIDTH-1:0]   vid_b,
	output logic                                vsync_n,
	output logic                                hsync_n,
	output logic                                csync_n,
	output logic                                vblank,
	output logic                                hblank,
	output logic                                cblank,
	output logic                                data_en,
	output logic                                underflow
);
	localparam int PW    = 3 * CHANNEL_BIT_WIDTH;  // Packed pixel width
	localparam int EW    = PW + 2;                 // Pixel plus two markers
	localparam int DEPTH = 1 << BUF_AW;

	//////////////////////////////////////////////////////////////////////////////

	// Window decode used for both dimensions
	function automatic logic in_window(input logic [15:0] cnt,
	                                   input logic [15:0] start,
	                                   input logic [15:0] len);
		logic [16:0] stop;
		stop = {1'b0, start} + {1'b0, len};
		return ({1'b0, cnt} >= {1'b0, start}) && ({1'b0, cnt} < stop);
	endfunction : in_window

	//////////////////////////////////////////////////////////////////////////////

	logic              gen_enable;   // Software run enable
	logic              flush;        // Clears buffer and sequencing
	logic [BUF_AW-1:0] wr_ptr_r;     // Buffer write pointer
	logic [BUF_AW-1:0] rd_ptr_r;     // Buffer read pointer
	logic [BUF_AW:0]   count_r;      // Entries visible to the reader
	logic              wr_d_r;       // Write seen last cycle
	logic              push;         // Accepted input beat
	logic              pop;          // Entry consumed
	logic [BUF_AW-1:0] rd_addr;      // Address presented to memory
	logic [EW-1:0]     head;         // Word at the read pointer
	logic              avail;        // Head word is valid
	logic              head_fs;      // Head carries frame start
	logic [15:0]       pix_div_r;    // Pixel rate divider
	logic              pix_en;       // One pixel slot
	run_state_t        state_r;      // Hunting or running
	logic [15:0]       h_cnt_r;      // Pixel within line
	logic [15:0]       v_cnt_r;      // Line within field
	logic              field_r;      // 0 first field, 1 second
	logic              line_end;     // Last pixel of a line
	logic              field_end;    // Last pixel of a field
	logic [15:0]       v_sync;       // Selected field sync lines
	logic [15:0]       v_bp;         // Selected field back porch
	logic [15:0]       v_act;        // Selected field active lines
	logic [15:0]       v_tot;        // Selected field total lines
	logic              h_sync_on;    // Horizontal sync interval
	logic              v_sync_on;    // Vertical sync interval
	logic              h_act_on;     // Horizontal active interval
	logic              v_act_on;     // Vertical active interval
	logic              want_pix;     // Output needs a pixel now
	logic              underflow_r;  // Sticky starvation flag

	//////////////////////////////////////////////////////////////////////////////

	// Register slave
	vtg_regs u_regs (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.gen_enable   (gen_enable),
		.st_underflow (underflow_r),
		.st_locked    (state_r == ST_RUN),
		.st_field     (field_r),
		.st_empty     (!avail)
	);

	// Disabling acts as a soft resynchronise
	assign flush = !gen_enable;

	//////////////////////////////////////////////////////////////////////////////
	// Input buffer

	assign in_ready = !flush && (({1'b0, count_r} + {{BUF_AW{1'b0}}, wr_d_r}) < DEPTH);
	assign push     = in_valid && in_ready;
	assign rd_addr  = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	assign avail    = (count_r != '0);
	assign head_fs  = head[EW-1];

	pixel_store #(
		.WIDTH (EW),
		.AW    (BUF_AW)
	) u_store (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (push),
		.wr_addr (wr_ptr_r),
		.wr_data ({in_frame_start, in_line_start, in_pixel}),
		.rd_addr (rd_addr),
		.rd_data (head)
	);

	// Pointers; the count lags a write by one cycle so data is readable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			wr_d_r   <= 1'b0;
		end else if (flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			wr_d_r   <= 1'b0;
		end else begin
			wr_d_r <= push;
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + {{BUF_AW{1'b0}}, wr_d_r} - {{BUF_AW{1'b0}}, pop};
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Pixel rate

	// Divider gives a one-cycle pixel slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_div_r <= `VTG_CNT_ZERO;
		end else if (pix_div_r >= 16'(PIX_DIV - 1)) begin
			pix_div_r <= `VTG_CNT_ZERO;
		end else begin
			pix_div_r <= pix_div_r + `VTG_CNT_ONE;
		end
	end
	assign pix_en = (pix_div_r >= 16'(PIX_DIV - 1));

	//////////////////////////////////////////////////////////////////////////////
	// Field parameter select

	// Each field has its own vertical set
	always_comb begin
		if (INTERLACE && field_r) begin
			v_sync = second_field_sync_lines;
			v_bp   = second_field_back_porch;
			v_act  = second_field_active_lines;
			v_tot  = second_field_total_lines;
		end else begin
			v_sync = frame_sync_lines;
			v_bp   = frame_back_porch;
			v_act  = frame_active_lines;
			v_tot  = frame_total_lines;
		end
	end

	// Front porches fill the remainder up to the totals
	assign line_end  = (h_cnt_r >= line_total_pixels - `VTG_CNT_ONE);
	assign field_end = line_end && (v_cnt_r >= v_tot - `VTG_CNT_ONE);

	// Sync, back porch, active, then front porch
	assign h_sync_on = in_window(h_cnt_r, `VTG_CNT_ZERO, line_sync_pixels);
	assign h_act_on  = in_window(h_cnt_r, 16'(line_sync_pixels + line_back_porch),
	                             line_active_pixels);
	assign v_sync_on = in_window(v_cnt_r, `VTG_CNT_ZERO, v_sync);
	assign v_act_on  = in_window(v_cnt_r, 16'(v_sync + v_bp), v_act);

	assign want_pix = (state_r == ST_RUN) && pix_en && h_act_on && v_act_on;

	//////////////////////////////////////////////////////////////////////////////
	// Frame lock

	// Drop beats until a frame start reaches the head
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_HUNT;
		end else if (flush) begin
			state_r <= ST_HUNT;
		end else begin
			case (state_r)
				ST_HUNT: begin
					if (pix_en && avail && head_fs) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					state_r <= ST_RUN;
				end
				default: begin
					state_r <= ST_HUNT;
				end
			endcase
		end
	end

	// Running pops on demand only, never realigns
	assign pop = avail && ((state_r == ST_HUNT && pix_en && !head_fs) || want_pix);

	//////////////////////////////////////////////////////////////////////////////
	// Timing counters

	// Pixels per slot, lines per line end
	// Counters restart from frame top on resync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_cnt_r <= `VTG_CNT_ZERO;
			v_cnt_r <= `VTG_CNT_ZERO;
		end else if (flush || state_r != ST_RUN) begin
			h_cnt_r <= `VTG_CNT_ZERO;
			v_cnt_r <= `VTG_CNT_ZERO;
		end else if (pix_en) begin
			if (line_end) begin
				h_cnt_r <= `VTG_CNT_ZERO;
				v_cnt_r <= field_end ? `VTG_CNT_ZERO : v_cnt_r + `VTG_CNT_ONE;
			end else begin
				h_cnt_r <= h_cnt_r + `VTG_CNT_ONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_r <= INTERLACE && START_FIELD;
		end else if (flush || state_r != ST_RUN) begin
			field_r <= INTERLACE && START_FIELD;
		end else if (pix_en && field_end && INTERLACE) begin
			field_r <= !field_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Flag follows the pixel slot timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underflow_r <= 1'b0;
		end else if (want_pix && !avail) begin
			// Set beats a disable in the same cycle, so no starvation is missed
			underflow_r <= 1'b1;
		end else if (flush) begin
			underflow_r <= 1'b0;
		end
	end
	assign underflow = underflow_r;

	// Sync and blank levels, idle while hunting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vsync_n <= 1'b1;
			hsync_n <= 1'b1;
			csync_n <= 1'b1;
			vblank  <= 1'b1;
			hblank  <= 1'b1;
			cblank  <= 1'b1;
			data_en <= 1'b0;
		end else if (state_r != ST_RUN) begin
			vsync_n <= 1'b1;
			hsync_n <= 1'b1;
			csync_n <= 1'b1;
			vblank  <= 1'b1;
			hblank  <= 1'b1;
			cblank  <= 1'b1;
			data_en <= 1'b0;
		end else if (pix_en) begin
			vsync_n <= !v_sync_on;
			hsync_n <= !h_sync_on;
			csync_n <= !(v_sync_on || h_sync_on);
			vblank  <= !v_act_on;
			hblank  <= !h_act_on;
			cblank  <= !(v_act_on && h_act_on);
			data_en <= h_act_on && v_act_on;
		end
	end

	// Pixel data; zero when blanked or starved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vid_r <= '0;
			vid_g <= '0;
			vid_b <= '0;
		end else if (pix_en || state_r != ST_RUN) begin
			if (want_pix && avail) begin
				vid_r <= head[3*CHANNEL_BIT_WIDTH-1:2*CHANNEL_BIT_WIDTH];
				vid_g <= head[2*CHANNEL_BIT_WIDTH-1:CHANNEL_BIT_WIDTH];
				vid_b <= head[CHANNEL_BIT_WIDTH-1:0];
			end else begin
				vid_r <= '0;
				vid_g <= '0;
				vid_b <= '0;
			end
		end
	end
endmodule : video_timing_generator

// >>> shared/vtg_map.svh
// Address map, field positions and reset values of the video timing generator
// Summary of operation
// - Horizontal counts pixels, vertical counts whole lines
// - Interlace only when build-time selection true
// - Build-time choice of starting field
// - Progressive mode ignores second-field inputs
// - Each field uses its own vertical values
// - Composite sync beside vertical and horizontal
// - Data enable high only on active pixels
// - Blanking high outside active video per dimension
// - Empty buffer on pixel demand raises underflow
// - No realignment after underflow until reset or disable
// - Reset resynchronises, clean within one frame
// - Pixel taken when valid and ready high
// - Invalid cycle pixel and markers ignored
// - Buffer pixels, lock on frame start first
// - Underflow flag timed by pixel rate logic
`ifndef VTG_MAP_SVH
`define VTG_MAP_SVH

// Register byte offsets
`define VTG_CTRL_OFS      8'h00
`define VTG_STATUS_OFS    8'h04

// Control fields
`define VTG_CTRL_EN_BIT   0
`define VTG_CTRL_RESET    32'h0000_0001

// Status fields
`define VTG_ST_UNDER_BIT  0
`define VTG_ST_LOCK_BIT   1
`define VTG_ST_FIELD_BIT  2
`define VTG_ST_EMPTY_BIT  3

// Counter constants
`define VTG_CNT_ZERO      16'h0000
`define VTG_CNT_ONE       16'h0001

`endif

// >>> shared/vtg_pkg.sv
// Types shared by the video timing generator files
package vtg_pkg;

	// Output sequencing states
	typedef enum logic [0:0] {
		ST_HUNT,
		ST_RUN
	} run_state_t;

endpackage : vtg_pkg

// >>> core/pixel_store.sv
// Small pixel memory with registered read data
`timescale 1ns/10ps
`include "vtg_map.svh"
module pixel_store import vtg_pkg::*; #(
	parameter int WIDTH = 26,
	parameter int AW    = 4
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read side
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [0:(1<<AW)-1];  // Storage array, no reset needed

	// Write port
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read every cycle; same-address write shows the old word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : pixel_store

// >>> core/vtg_regs.sv
// APB register slave: control and status of the timing generator
`timescale 1ns/10ps
`include "vtg_map.svh"
module vtg_regs import vtg_pkg::*; (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Block side
	output logic             gen_enable,
	input  wire logic        st_underflow,
	input  wire logic        st_locked,
	input  wire logic        st_field,
	input  wire logic        st_empty
);
	logic [31:0] ctrl_r;   // Control word
	logic        access;   // Access phase of a transfer
	logic        mapped;   // Address hits a register

	assign access     = psel && penable;
	assign mapped     = (paddr == `VTG_CTRL_OFS) || (paddr == `VTG_STATUS_OFS);
	// Zero wait states keep the host simple
	assign pready     = 1'b1;
	assign pslverr    = access && !mapped;
	assign gen_enable = ctrl_r[`VTG_CTRL_EN_BIT];

	// Control write; only the enable bit is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `VTG_CTRL_RESET;
		end else if (access && pwrite && paddr == `VTG_CTRL_OFS) begin
			ctrl_r <= pwdata & `VTG_CTRL_RESET;
		end
	end

	// Read mux; unmapped reads give zero
	always_comb begin
		prdata = '0;
		if (access && !pwrite) begin
			case (paddr)
				`VTG_CTRL_OFS: begin
					prdata = ctrl_r;
				end
				`VTG_STATUS_OFS: begin
					prdata[`VTG_ST_UNDER_BIT] = st_underflow;
					prdata[`VTG_ST_LOCK_BIT]  = st_locked;
					prdata[`VTG_ST_FIELD_BIT] = st_field;
					prdata[`VTG_ST_EMPTY_BIT] = st_empty;
				end
				default: begin
					prdata = '0;
				end
			endcase
		end
	end
endmodule : vtg_regs

// >>> tb/vtg_checker.sv
// Checker of sync, blank and enable timing at the generator ports
`timescale 1ns/10ps
`include "vtg_map.svh"
module vtg_checker #(
	parameter int CHANNEL_BIT_WIDTH = 8
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	// Timing inputs
	input wire logic [15:0] line_sync_pixels,
	input wire logic [15:0] line_back_porch,
	input wire logic [15:0] line_active_pixels,
	input wire logic [15:0] line_total_pixels,
	input wire logic [15:0] frame_sync_lines,
	// Video outputs
	input wire logic [CHANNEL_BIT_WIDTH-1:0] vid_r,
	input wire logic [CHANNEL_BIT_WIDTH-1:0] vid_g,
	input wire logic [CHANNEL_BIT_WIDTH-1:0] vid_b,
	input wire logic        vsync_n,
	input wire logic        hsync_n,
	input wire logic        csync_n,
	input wire logic        vblank,
	input wire logic        hblank,
	input wire logic        cblank,
	input wire logic        data_en,
	input wire logic        underflow
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Run lengths; cleared by reset so a line cut by reset never fires
	logic [15:0] hs_low_r;  // Cycles hsync held low
	logic [15:0] hs_high_r; // Cycles since hsync rose
	logic [15:0] de_run_r;  // Cycles enable held high
	logic [31:0] vs_low_r;  // Cycles vsync held low
	logic        ctrl_wr;   // Control write may clear underflow
	assign ctrl_wr = psel && penable && pwrite && (paddr == `VTG_CTRL_OFS);
	// Counters of output run lengths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_low_r  <= 16'h0000;
			hs_high_r <= 16'h0000;
			de_run_r  <= 16'h0000;
			vs_low_r  <= 32'h0000_0000;
		end else begin
			hs_low_r  <= hsync_n ? 16'h0000 : hs_low_r + 16'h0001;
			hs_high_r <= hsync_n ? hs_high_r + 16'h0001 : 16'h0000;
			de_run_r  <= data_en ? de_run_r + 16'h0001 : 16'h0000;
			vs_low_r  <= vsync_n ? 32'h0000_0000 : vs_low_r + 32'h0000_0001;
		end
	end
	// End of a line sync pulse
	sequence line_sync_end;
		$rose(hsync_n);
	endsequence
	// Start of a frame sync pulse
	sequence frame_sync_start;
		$fell(vsync_n);
	endsequence
	a_csync_and: assert property (csync_n == (vsync_n & hsync_n))
		else $error("composite sync differs from the two syncs");
	a_cblank_or: assert property (cblank == (vblank | hblank))
		else $error("composite blank differs from the two blanks");
	a_de_unblank: assert property (data_en == !cblank)
		else $error("data enable and blanking disagree");
	a_video_dark: assert property (!data_en |-> ({vid_r, vid_g, vid_b} == '0))
		else $error("video not zero outside active pixels");
	a_hsync_width: assert property (line_sync_end |-> hs_low_r == line_sync_pixels)
		else $error("line sync width wrong");
	a_porch_gap: assert property ($rose(data_en) |-> hs_high_r == line_back_porch)
		else $error("back porch length wrong");
	a_active_run: assert property ($fell(data_en) |-> de_run_r == line_active_pixels)
		else $error("active run length wrong");
	a_vsync_width: assert property ($rose(vsync_n) |->
		vs_low_r == frame_sync_lines * line_total_pixels)
		else $error("frame sync length wrong");
	a_frame_align: assert property (frame_sync_start |-> $fell(hsync_n))
		else $error("frame sync not on a line start");
	a_under_stick: assert property (underflow && !ctrl_wr && !$past(ctrl_wr) |=> underflow)
		else $error("underflow flag dropped");
endmodule : vtg_checker
////////////////////////////////////////////////////////////////////////////////
bind video_timing_generator vtg_checker #(.CHANNEL_BIT_WIDTH(CHANNEL_BIT_WIDTH)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.line_sync_pixels, .line_back_porch, .line_active_pixels, .line_total_pixels,
	.frame_sync_lines, .vid_r, .vid_g, .vid_b, .vsync_n, .hsync_n, .csync_n,
	.vblank, .hblank, .cblank, .data_en, .underflow);

// >>> tb/display_sink.sv
// Display side model: latches enabled pixels and counts frames
`timescale 1ns/10ps
module display_sink #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// Video from the generator
	input wire logic [W-1:0]  vid_r,
	input wire logic [W-1:0]  vid_g,
	input wire logic [W-1:0]  vid_b,
	input wire logic          vsync_n,
	input wire logic          data_en,
	// Captured results
	output logic              px_stb,
	output logic [3*W-1:0]    px_val,
	output logic [15:0]       frames
);
	logic vs_d_r; // Previous sync level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			px_stb <= 1'b0;
			px_val <= '0;
		end else begin
			px_stb <= data_en;
			px_val <= {vid_r, vid_g, vid_b};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_d_r <= 1'b1;
			frames <= 16'h0000;
		end else begin
			vs_d_r <= vsync_n;
			if (vs_d_r && !vsync_n) begin
				frames <= frames + 16'h0001;
			end
		end
	end
endmodule : display_sink

// >>> tb/video_timing_generator_tb.sv
// Self-checking bench of the video timing generator
`timescale 1ns/10ps
`include "vtg_map.svh"
module video_timing_generator_tb;
	// Small timing so a frame is 50 cycles
	localparam int HS = 2, HB = 2, HA = 4, HT = 10;
	localparam int VS = 1, VB = 1, VA = 2, VT = 5;
	// Bench state
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic er, in_frame_start, in_line_start, in_valid, in_ready, px_stb;
	logic [23:0] in_pixel, px_val;
	logic [7:0] vid_r, vid_g, vid_b;
	logic vsync_n, hsync_n, csync_n, vblank, hblank, cblank, data_en, underflow;
	logic [15:0] frames;
	logic [23:0] exp_q[$]; // Pixels expected in display order
	int seed, bad_count, n_tests, cyc;
	logic [15:0] tm [10]; // Timing inputs, line values then frame values
	////////////////////////////////////////////////////////////////////////
	video_timing_generator dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr,
		.line_sync_pixels(tm[0]), .line_back_porch(tm[1]), .line_front_porch(tm[2]),
		.line_active_pixels(tm[3]), .line_total_pixels(tm[4]), .frame_sync_lines(tm[5]),
		.frame_back_porch(tm[6]), .frame_front_porch(tm[7]),
		.frame_active_lines(tm[8]), .frame_total_lines(tm[9]),
		// progressive build, second field held at zero
		.second_field_sync_lines(16'h0000), .second_field_back_porch(16'h0000),
		.second_field_front_porch(16'h0000), .second_field_active_lines(16'h0000),
		.second_field_total_lines(16'h0000),
		.in_pixel, .in_frame_start, .in_line_start, .in_valid, .in_ready,
		.vid_r, .vid_g, .vid_b, .vsync_n, .hsync_n, .csync_n,
		.vblank, .hblank, .cblank, .data_en, .underflow);
	display_sink #(.W(8)) u_sink (.pclk, .presetn, .vid_r, .vid_g, .vid_b,
		.vsync_n, .data_en, .px_stb, .px_val, .frames);
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task close_out;
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// Compare one value
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task send(input logic [23:0] p, input logic fs, input logic ls);
		logic rdy;
		in_pixel <= p;
		in_frame_start <= fs;
		in_line_start <= ls;
		in_valid <= 1'b1;
		do begin
			@(negedge pclk) rdy = in_ready;
			@(posedge pclk);
		end while (!rdy);
		rnd = $random(seed);
		if (rnd[0]) begin
			in_valid <= 1'b0;
			in_pixel <= rnd[31:8];
			in_frame_start <= rnd[1];
			in_line_start <= rnd[2];
			@(posedge pclk);
		end
	endtask : send
	task send_frame;
		for (int i = 0; i < VA * HA; i++) begin
			rnd = $random(seed);
			exp_q.push_back(rnd[23:0]);
			send(rnd[23:0], i == 0, i % HA == 0);
		end
	endtask : send_frame
	// Reset held two cycles, model emptied
	task do_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		exp_q.delete();
	endtask : do_reset
	// Wait for the model to empty, bounded
	task drain;
		for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge pclk);
		chk(exp_q.size(), 0);
	endtask : drain
	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out;
		end
	end
	// Model compare at every displayed pixel
	always @(posedge pclk) begin
		if (px_stb && exp_q.size() > 0) chk(px_val, exp_q.pop_front());
	end
	// Main sequence
	initial begin
		seed = 45594;
		// timing values fixed before reset is released
		tm = '{16'(HS), 16'(HB), 16'(HT-HS-HB-HA), 16'(HA), 16'(HT),
			16'(VS), 16'(VB), 16'(VT-VS-VB-VA), 16'(VA), 16'(VT)};
		{presetn, psel, penable, pwrite, in_valid, in_frame_start, in_line_start} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		in_pixel = 24'h000000;
		@(posedge pclk);
		do_reset;
		apb(1'b0, `VTG_CTRL_OFS, 32'h0000_0000);
		chk(rd, `VTG_CTRL_RESET);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({rd[30:0], er}, 32'h0000_0001);
		// junk ahead of the first frame is dropped
		repeat (3) send(24'hA5A5A5, 1'b0, 1'b1);
		repeat (3) send_frame;
		in_valid <= 1'b0;
		drain;
		for (int i = 0; i < 120 && !underflow; i++) @(posedge pclk);
		chk(underflow, 1'b1);
		apb(1'b0, `VTG_STATUS_OFS, 32'h0000_0000);
		chk(rd[`VTG_ST_UNDER_BIT], 1'b1);
		repeat (60) @(posedge pclk);
		chk(underflow, 1'b1);
		// Disable on a back porch line, away from any pulse edge
		while (vsync_n !== 1'b0) @(posedge pclk);
		while (vsync_n !== 1'b1) @(posedge pclk);
		apb(1'b1, `VTG_CTRL_OFS, 32'h0000_0000);
		@(posedge pclk);
		chk(underflow, 1'b0);
		chk(in_ready, 1'b0);
		apb(1'b1, `VTG_CTRL_OFS, 32'h0000_0001);
		apb(1'b0, `VTG_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		do_reset;
		chk(underflow, 1'b0);
		chk(in_ready, 1'b1);
		repeat (2) send_frame;
		in_valid <= 1'b0;
		drain;
		chk(frames, 32'h0000_0002);
		close_out;
	end
endmodule : video_timing_generator_tb
